// File: verification/ccr_charger_control_regs_tb_top.sv
// Self-checking bench for the charger control register block
`timescale 1ns/1ns

module ccr_charger_control_regs_tb_top;
    logic                clk_sys;
    logic                reset;
    logic [7:0]          reg_addr;
    logic                reg_wr;
    logic [7:0]          reg_wdata;
    logic                reg_rd;
    logic [7:0]          reg_rdata;
    ccr_pkg::ccr_sense_t env;
    ccr_pkg::ccr_sense_t sense_in;
    ccr_pkg::ccr_ctrl_t  ctrl_out;
    logic [7:0]          lag;
    logic [7:0]          shadow [logic [7:0]];
    logic [7:0]          rd;
    logic [7:0]          a;
    logic [7:0]          d;
    int                  err_total;
    int                  comparisons;
    int                  cycles;

    // Short tick keeps the termination timer within a short run
    ccr_charger_control_regs #(.TICK_CYCLES(32'd10))
        ccr_charger_control_regs_i (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .reg_addr (reg_addr),
        .reg_wr   (reg_wr),
        .reg_wdata(reg_wdata),
        .reg_rd   (reg_rd),
        .reg_rdata(reg_rdata),
        .sense_in (sense_in),
        .ctrl_out (ctrl_out)
    );

    ccr_far_side_model ccr_far_side_model_i (
        .clk_sys(clk_sys),
        .env    (env),
        .ctrl   (ctrl_out),
        .lag    (lag),
        .sense  (sense_in)
    );

    // ==========================================================
    // Clock, hang guard and reporting
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("counts: %0d compared, %0d bad", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic bad(input logic [7:0] got, input logic [7:0] exp);
        err_total++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    endtask

    // ==========================================================
    // Register port and shadow model
    task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
        @(posedge clk_sys);
        reg_addr  <= ad;
        reg_wdata <= dt;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        // Change flags are checked directly, only storage bits shadowed
        if (ad == 8'h97) shadow[ad] = dt & 8'hfc;
        else if (shadow.exists(ad)) shadow[ad] = dt;
    endtask

    task automatic chk_rd(input logic [7:0] ad, input logic [7:0] m,
                          input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= ad;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1 rd = reg_rdata;
        comparisons++;
        if ((rd & m) !== (exp & m)) bad(rd & m, exp & m);
    endtask

    task automatic chk_ctl(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) bad(got, exp);
    endtask

    function automatic logic [7:0] stat(input logic [1:0] md,
                                        input logic tmo);
        return {env.input_current_limited, tmo, env.bat_unrecoverable, md,
                env.bat_hot, env.bat_cold, env.adapter_present};
    endfunction

    // ==========================================================
    // Main sequence
    initial begin
        reset = 1'b1;
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
        env = '0;
        lag = 8'd30;
        shadow = '{8'h90:8'h80, 8'h92:8'h04, 8'h93:8'h78, 8'h94:8'h00,
                   8'h97:8'h00};
        void'($urandom(32'hfb38703e));
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        foreach (shadow[i]) chk_rd(i, 8'hff, shadow[i]);
        chk_ctl({ctrl_out.battery_good_threshold, 6'h0}, 8'hc0);
        chk_ctl({5'h0, ctrl_out.recovery_charge_current}, 8'h03);
        wr(8'h91, 8'h5a);
        chk_rd(8'h91, 8'hff, 8'h00);
        wr(8'h95, 8'hff);
        chk_rd(8'h95, 8'hff, stat(2'h0, 1'b0));
        $display("test reset_values done");

        for (int i = 0; i < 12; i++) begin
            a = 8'h92 + 8'(i % 3);
            if (i % 4 == 3) a = 8'h97;
            d = 8'($urandom());
            if (a == 8'h94) d[0] = 1'b1;
            wr(a, d);
            chk_rd(a, (a == 8'h97) ? 8'hfc : 8'hff, shadow[a]);
            @(posedge clk_sys);
            chk_ctl({7'h0, ctrl_out.termination_current_select},
                    {7'h0, shadow[8'h92][7]});
            chk_ctl({ctrl_out.recovery_charge_current,
                     ctrl_out.battery_good_threshold, 2'h0,
                     ctrl_out.undervoltage_lockout_select},
                    shadow[8'h93] & 8'hf9);
            chk_ctl({3'h0, ctrl_out.constant_current_loop_off,
                     ctrl_out.constant_voltage_loop_off,
                     ctrl_out.thermistor_functions_off, 2'h0},
                    shadow[8'h94] & 8'h1c);
        end
        $display("test random_fields done");

        wr(8'h94, 8'h01);
        for (int i = 0; i < 6; i++) begin
            d = 8'($urandom());
            env.adapter_present <= d[0];
            env.bat_cold <= d[1];
            env.bat_hot <= d[2];
            env.bat_unrecoverable <= d[5];
            env.input_current_limited <= d[7];
            repeat (5) @(posedge clk_sys);
            chk_rd(8'h95, 8'hff, stat(2'h0, 1'b0));
        end
        env <= '0;
        wr(8'h94, 8'h00);
        wr(8'h97, 8'h03);
        env.input_current_limited <= 1'b1;
        repeat (5) @(posedge clk_sys);
        chk_rd(8'h97, 8'h02, 8'h02);
        wr(8'h97, 8'h02);
        chk_rd(8'h97, 8'h02, 8'h00);
        env.input_current_limited <= 1'b0;
        repeat (5) @(posedge clk_sys);
        wr(8'h97, 8'h03);
        $display("test status_flags done");

        for (int m = 0; m < 4; m++) begin
            lag <= (m == 1) ? 8'd4 : 8'd30;
            wr(8'h92, {1'b0, (m == 2) ? 5'h1f : 5'h01, 2'(m)});
            env.adapter_present <= 1'b1;
            repeat (8) @(posedge clk_sys);
            if (m != 1) chk_rd(8'h95, 8'h18, 8'h10);
            repeat (200) @(posedge clk_sys);
            chk_rd(8'h95, 8'hff, stat(2'h0, m < 2));
            env.recharge_needed <= (m == 3);
            repeat (4) @(posedge clk_sys);
            chk_rd(8'h95, 8'h18, (m == 3) ? 8'h10 : 8'h00);
            // Clear the flag left by insertion so removal must set it
            wr(8'h97, 8'h01);
            env.adapter_present <= 1'b0;
            repeat (6) @(posedge clk_sys);
            chk_rd(8'h97, 8'h01, 8'h01);
            wr(8'h97, 8'h01);
            chk_rd(8'h97, 8'h01, 8'h00);
        end
        $display("test termination_methods done");

        env.below_battery_good <= 1'b1;
        env.adapter_present <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk_rd(8'h95, 8'h18, 8'h08);
        chk_ctl({6'h0, ctrl_out.charger_mode}, 8'h01);
        env.vsys_low <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk_rd(8'h95, 8'h18, 8'h00);
        chk_ctl({7'h0, ctrl_out.charge_enable}, 8'h00);
        wr(8'h94, 8'h20);
        repeat (8) @(posedge clk_sys);
        chk_rd(8'h95, 8'h18, 8'h08);
        chk_ctl({7'h0, ctrl_out.charge_reduce}, 8'h01);
        env.vsys_low <= 1'b0;
        wr(8'h94, 8'h01);
        repeat (8) @(posedge clk_sys);
        chk_rd(8'h95, 8'h18, 8'h00);
        $display("test priority done");

        wr(8'h90, 8'h00);
        for (int p = 0; p < 2; p++) begin
            env.external_limit_pin <= p[0];
            repeat (5) @(posedge clk_sys);
            chk_ctl({6'h0, ctrl_out.internal_limit_source,
                     ctrl_out.limit_high_from_pin}, 8'(p));
        end
        $display("test limit_source done");
        end_of_test();
    end
endmodule // ccr_charger_control_regs_tb_top

// File: verification/ccr_far_side_model.sv
// Behavioural battery and supply that answer the charger controls
`timescale 1ns/1ns

module ccr_far_side_model (
    input  wire logic                clk_sys,
    input  wire ccr_pkg::ccr_sense_t env,
    input  wire ccr_pkg::ccr_ctrl_t  ctrl,
    input  wire logic [7:0]          lag,
    output ccr_pkg::ccr_sense_t      sense
);
    logic [7:0] chg_cnt_reg;
    logic       cc_now;
    logic       cv_now;

    // ==========================================================
    // Battery voltage climbs only while fast charging
    assign cc_now = ctrl.charger_mode == 2'h2;
    assign cv_now = ctrl.charger_mode == 2'h3;

    always_ff @(posedge clk_sys) begin
        if (!(cc_now || cv_now)) begin
            chg_cnt_reg <= 8'h00;
        end else if (chg_cnt_reg != 8'hff) begin
            chg_cnt_reg <= chg_cnt_reg + 8'h01;
        end
    end

    // Taper to the end current ends at twice the climb count, about one more climb time
    always_comb begin
        sense = env;
        sense.cv_reached = env.cv_reached | (cc_now && chg_cnt_reg >= lag);
        sense.at_term_current = env.at_term_current |
            (cv_now && {1'b0, chg_cnt_reg} >= {lag, 1'b0});
    end
endmodule // ccr_far_side_model

// File: verilog/ccr_charger_control_regs.sv
// Charger control and status registers with charge sequencing
// Contract
// - Method 00: timer starts at termination current; expiry ends charge
// - Method 01: timer starts on constant voltage entry; expiry ends charge
// - Method 10: charge ends when termination current reached, no timer
// - Method 11: first of timer expiry or termination current ends charge
// - Timer is count times 2 min, or 10 min if method low bit set
// - Termination control bit 7 selects 100 mA set, 50 mA clear
// - Settings bit 0 selects lockout 3.95 V set, 4.15 V clear
// - Battery-good field picks 2.50 to 2.80 V; below it use recovery
// - Recovery current field gives 25 mA times code plus one
// - Special bits 0 to 4 disable charger, recharge, thermistor, CV, CC
// - Priority clear: stop charging while system rail below 3.6 V
// - Priority set: reduce charge current while system rail below 3.6 V
// - Status bit 0 reads one while adapter inserted, read only
// - Status bits 1 and 2 report battery too cold and too hot
// - Mode field: 00 hold, 01 recovery, 10 constant current, 11 voltage
// - Status bit 5 set when battery low and unrecoverable
// - Status bit 6 set when charge ended by timer expiry
// - Status bit 7 set while input current is limited
// - Adapter and limit change flags set on change, write one clears
// - Limit source clear: limit follows pin, 500 mA low, 1.5 A high
`timescale 1ns/1ns
`include "ccr_consts.svh"

module ccr_charger_control_regs #(
    parameter logic [31:0] TICK_CYCLES = 32'(`CCR_TICK_CYCLES)
) (
    input  wire logic                clk_sys,
    input  wire logic                reset,
    input  wire logic [7:0]          reg_addr,
    input  wire logic                reg_wr,
    input  wire logic [7:0]          reg_wdata,
    input  wire logic                reg_rd,
    output logic [7:0]               reg_rdata,
    input  wire ccr_pkg::ccr_sense_t sense_in,
    output ccr_pkg::ccr_ctrl_t       ctrl_out
);

    // ==========================================================
    // Functions
    function automatic logic [7:0] ccr_target(input logic [1:0] meth,
                                              input logic [4:0] cnt);
        logic [7:0] base;
        base = {3'h0, cnt};
        ccr_target = meth[0] ? 8'(base * `CCR_LONG_MULT) : base;
    endfunction

    function automatic logic [1:0] ccr_mode(input ccr_pkg::ccr_state_t s);
        case (s)
            ccr_pkg::CCR_RECOVERY: ccr_mode = 2'h1;
            ccr_pkg::CCR_CC:       ccr_mode = 2'h2;
            ccr_pkg::CCR_CV:       ccr_mode = 2'h3;
            default:               ccr_mode = 2'h0;
        endcase
    endfunction

    // ==========================================================
    // Pin synchronisers
    ccr_pkg::ccr_sense_t sense_meta_reg;
    ccr_pkg::ccr_sense_t s_reg;
    ccr_pkg::ccr_sense_t s_prev_reg;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sense_meta_reg <= '0;
            s_reg          <= '0;
            s_prev_reg     <= '0;
        end else begin
            sense_meta_reg <= sense_in;
            s_reg          <= sense_meta_reg;
            s_prev_reg     <= s_reg;
        end
    end

    // ==========================================================
    // Register file
    logic [7:0] limit_cfg_reg;
    logic [7:0] term_ctrl_reg;
    logic [7:0] app_set_reg;
    logic [7:0] special_reg;
    logic [7:0] int_status_reg;
    logic [7:0] int_status_next;
    logic [7:0] reg_rdata_reg;
    logic [7:0] rdata_next;

    wire wr_limit   = reg_wr && (reg_addr == `CCR_ADDR_LIMIT_CFG);
    wire wr_term    = reg_wr && (reg_addr == `CCR_ADDR_TERM_CTRL);
    wire wr_app     = reg_wr && (reg_addr == `CCR_ADDR_APP_SET);
    wire wr_special = reg_wr && (reg_addr == `CCR_ADDR_SPECIAL);
    wire wr_int     = reg_wr && (reg_addr == `CCR_ADDR_INT_STATUS);

    // Whole bytes stored, reserved bits included but never decoded
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            limit_cfg_reg <= `CCR_RST_LIMIT_CFG;
            term_ctrl_reg <= `CCR_RST_TERM_CTRL;
            app_set_reg   <= `CCR_RST_APP_SET;
            special_reg   <= `CCR_RST_SPECIAL;
        end else begin
            if (wr_limit)   limit_cfg_reg <= reg_wdata;
            if (wr_term)    term_ctrl_reg <= reg_wdata;
            if (wr_app)     app_set_reg   <= reg_wdata;
            if (wr_special) special_reg   <= reg_wdata;
        end
    end

    wire [1:0] method    = term_ctrl_reg[`CCR_TERM_METHOD_LSB +: 2];
    wire [4:0] timer_cnt = term_ctrl_reg[`CCR_TERM_TIMER_LSB +: 5];
    wire charger_off     = special_reg[`CCR_SPC_CHARGER_OFF];
    wire recharge_off    = special_reg[`CCR_SPC_RECHARGE_OFF];
    wire therm_off       = special_reg[`CCR_SPC_THERM_OFF];
    wire charge_priority = special_reg[`CCR_SPC_PRIORITY];

    // ==========================================================
    // Change flags: a change in the clearing cycle still sets
    wire adapter_chg = s_reg.adapter_present != s_prev_reg.adapter_present;
    wire limit_chg   = s_reg.input_current_limited !=
                       s_prev_reg.input_current_limited;

    always_comb begin
        int_status_next = int_status_reg;
        if (wr_int) begin
            int_status_next[7:2] = reg_wdata[7:2];
            int_status_next[1:0] = int_status_reg[1:0] & ~reg_wdata[1:0];
        end
        if (adapter_chg)
            int_status_next[`CCR_INT_ADAPTER_BIT] = 1'b1;
        if (limit_chg)
            int_status_next[`CCR_INT_LIMIT_BIT] = 1'b1;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) int_status_reg <= `CCR_RST_INT_STATUS;
        else       int_status_reg <= int_status_next;
    end

    // ==========================================================
    // Charge sequencer
    ccr_pkg::ccr_state_t state_reg;
    ccr_pkg::ccr_state_t state_next;
    logic        timer_run_reg;
    logic        timer_run_next;
    logic [30:0] tick_cnt_reg;
    logic [7:0]  min_cnt_reg;
    logic        timeout_reg;
    logic        timeout_next;

    wire in_cv      = state_reg == ccr_pkg::CCR_CV;
    wire temp_fault = (s_reg.bat_cold || s_reg.bat_hot) && !therm_off;
    wire stop_rail  = s_reg.vsys_low && !charge_priority;
    wire go_hold    = !s_reg.adapter_present || charger_off;
    wire abort      = go_hold || temp_fault || stop_rail ||
                      s_reg.bat_unrecoverable;
    wire [7:0] target = ccr_target(method, timer_cnt);
    // Method 10 never runs the timer, so its count has no effect
    wire timer_allowed = method != `CCR_METH_CURRENT;
    wire timer_start   = in_cv && timer_allowed &&
                         (method[0] ||
                          s_reg.at_term_current);
    wire expired    = timer_run_reg && (min_cnt_reg >= target);
    wire done_timer = in_cv && timer_allowed && expired;
    wire done_cur   = in_cv && method[1] && s_reg.at_term_current;
    wire tick       = tick_cnt_reg == 31'(TICK_CYCLES - 32'h1);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ccr_pkg::CCR_HOLD: begin
                if (!abort)
                    state_next = s_reg.below_battery_good ?
                                 ccr_pkg::CCR_RECOVERY :
                                 ccr_pkg::CCR_CC;
            end
            ccr_pkg::CCR_RECOVERY: begin
                if (abort)
                    state_next = ccr_pkg::CCR_HOLD;
                else if (!s_reg.below_battery_good)
                    state_next = ccr_pkg::CCR_CC;
            end
            ccr_pkg::CCR_CC: begin
                if (abort)
                    state_next = ccr_pkg::CCR_HOLD;
                else if (s_reg.cv_reached)
                    state_next = ccr_pkg::CCR_CV;
            end
            ccr_pkg::CCR_CV: begin
                if (abort)
                    state_next = ccr_pkg::CCR_HOLD;
                else if (done_timer || done_cur)
                    state_next = ccr_pkg::CCR_DONE;
            end
            ccr_pkg::CCR_DONE: begin
                if (go_hold)
                    state_next = ccr_pkg::CCR_HOLD;
                else if (s_reg.recharge_needed && !recharge_off)
                    state_next = ccr_pkg::CCR_CC;
            end
            default: state_next = ccr_pkg::CCR_HOLD;
        endcase
    end

    always_comb begin
        timer_run_next = timer_run_reg || timer_start;
        if (!in_cv || state_next != ccr_pkg::CCR_CV)
            timer_run_next = 1'b0;
        timeout_next = timeout_reg;
        if (state_reg == ccr_pkg::CCR_DONE &&
            state_next != ccr_pkg::CCR_DONE)
            timeout_next = 1'b0;
        if (done_timer && !abort)
            timeout_next = 1'b1;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_reg     <= ccr_pkg::CCR_HOLD;
            timer_run_reg <= 1'b0;
            timeout_reg   <= 1'b0;
        end else begin
            state_reg     <= state_next;
            timer_run_reg <= timer_run_next;
            timeout_reg   <= timeout_next;
        end
    end

    // Counts two-minute ticks; saturates so a long wait cannot wrap
    always_ff @(posedge clk_sys) begin
        if (reset || !timer_run_reg) begin
            tick_cnt_reg <= 31'h0;
            min_cnt_reg  <= 8'h0;
        end else if (tick) begin
            tick_cnt_reg <= 31'h0;
            if (min_cnt_reg != 8'hff)
                min_cnt_reg <= min_cnt_reg + 8'h1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 31'h1;
        end
    end

    // ==========================================================
    // Status byte and read port; reads change no state
    wire [7:0] status_one = {
        s_reg.input_current_limited,
        timeout_reg,
        s_reg.bat_unrecoverable,
        ccr_mode(state_reg),
        s_reg.bat_hot,
        s_reg.bat_cold,
        s_reg.adapter_present
    };

    always_comb begin
        case (reg_addr)
            `CCR_ADDR_LIMIT_CFG:  rdata_next = limit_cfg_reg;
            `CCR_ADDR_TERM_CTRL:  rdata_next = term_ctrl_reg;
            `CCR_ADDR_APP_SET:    rdata_next = app_set_reg;
            `CCR_ADDR_SPECIAL:    rdata_next = special_reg;
            `CCR_ADDR_STATUS_ONE: rdata_next = status_one;
            `CCR_ADDR_INT_STATUS: rdata_next = int_status_reg;
            default:              rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset)       reg_rdata_reg <= 8'h00;
        else if (reg_rd) reg_rdata_reg <= rdata_next;
    end

    assign reg_rdata = reg_rdata_reg;

    // ==========================================================
    // Controls to the analog side
    ccr_pkg::ccr_ctrl_t ctrl_reg;
    ccr_pkg::ccr_ctrl_t ctrl_next;
    wire charging = state_reg == ccr_pkg::CCR_RECOVERY ||
                    state_reg == ccr_pkg::CCR_CC || in_cv;

    always_comb begin
        ctrl_next.charge_enable  = charging && !stop_rail;
        ctrl_next.charge_reduce  = charging && charge_priority &&
                                   s_reg.vsys_low;
        ctrl_next.constant_voltage_loop_off =
            special_reg[`CCR_SPC_CV_OFF];
        ctrl_next.constant_current_loop_off =
            special_reg[`CCR_SPC_CC_OFF];
        ctrl_next.thermistor_functions_off = therm_off;
        ctrl_next.termination_current_select =
            term_ctrl_reg[`CCR_END_CURRENT_BIT];
        ctrl_next.undervoltage_lockout_select =
            app_set_reg[`CCR_UVLO_BIT];
        ctrl_next.battery_good_threshold =
            app_set_reg[`CCR_BATGD_LSB +: 2];
        ctrl_next.recovery_charge_current =
            app_set_reg[`CCR_REC_CUR_LSB +: 3];
        ctrl_next.internal_limit_source =
            limit_cfg_reg[`CCR_LIMIT_SRC_BIT];
        ctrl_next.limit_high_from_pin = s_reg.external_limit_pin;
        ctrl_next.charger_mode = ccr_mode(state_reg);
    end

    always_ff @(posedge clk_sys) begin
        if (reset) ctrl_reg <= '0;
        else       ctrl_reg <= ctrl_next;
    end

    assign ctrl_out = ctrl_reg;

    // ==========================================================
    // Assertions
    default clocking ccr_cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    AST_METHOD_CURRENT_ENDS: assert property (
        in_cv && method == `CCR_METH_CURRENT && s_reg.at_term_current &&
        !abort |=> state_reg == ccr_pkg::CCR_DONE)
        else $error("Current termination did not end charge");

    AST_METHOD_ZERO_WAITS: assert property (
        in_cv && method == `CCR_METH_AFTER_TERM && !timer_run_reg &&
        !s_reg.at_term_current |=> !timer_run_reg)
        else $error("Timer started before termination current");

    AST_CV_ENTRY_STARTS: assert property (
        in_cv && method[0] && !abort && !done_cur
        |=> timer_run_reg || state_reg != ccr_pkg::CCR_CV)
        else $error("Timer not started in constant voltage");

    AST_TIMEOUT_CAUSE: assert property (
        $rose(timeout_reg) |-> $past(done_timer) &&
        state_reg == ccr_pkg::CCR_DONE)
        else $error("Timeout flag without timer expiry");

    AST_ADAPTER_FLAG: assert property (
        adapter_chg |=> int_status_reg[`CCR_INT_ADAPTER_BIT])
        else $error("Adapter change flag lost");

    AST_RAIL_STOP: assert property (
        charging && s_reg.vsys_low && !charge_priority
        |=> !ctrl_out.charge_enable)
        else $error("Charging not stopped on low rail");

    AST_RAIL_REDUCE: assert property (
        charging && s_reg.vsys_low && charge_priority
        |=> ctrl_out.charge_reduce && ctrl_out.charge_enable)
        else $error("Charge not reduced on low rail");

    AST_CHARGER_OFF: assert property (
        charger_off |=> state_reg == ccr_pkg::CCR_HOLD
        ##1 !ctrl_out.charge_enable)
        else $error("Disabled charger still charging");

    AST_STATUS_READ: assert property (
        reg_rd && reg_addr == `CCR_ADDR_STATUS_ONE
        |=> reg_rdata[0] == $past(s_reg.adapter_present))
        else $error("Adapter status misreported");

    AST_TERMINATION_CURRENT_SELECT_SEL: assert property (
        wr_term ##2 !wr_term
        |-> ctrl_out.termination_current_select == $past(reg_wdata[7], 2))
        else $error("Termination current select not applied");

endmodule // ccr_charger_control_regs

// File: verilog/ccr_consts.svh
// Register offsets, field positions, reset values and timing constants
`ifndef CCR_CONSTS_SVH
`define CCR_CONSTS_SVH

// ==========================================================
// Register offsets
`define CCR_ADDR_LIMIT_CFG   8'h90
`define CCR_ADDR_TERM_CTRL   8'h92
`define CCR_ADDR_APP_SET     8'h93
`define CCR_ADDR_SPECIAL     8'h94
`define CCR_ADDR_STATUS_ONE  8'h95
`define CCR_ADDR_INT_STATUS  8'h97

// ==========================================================
// Reset values
`define CCR_RST_LIMIT_CFG    8'h80
`define CCR_RST_TERM_CTRL    8'h04
`define CCR_RST_APP_SET      8'h78
`define CCR_RST_SPECIAL      8'h00
`define CCR_RST_INT_STATUS   8'h00

// ==========================================================
// Field positions
`define CCR_TERM_METHOD_LSB  0
`define CCR_TERM_TIMER_LSB   2
`define CCR_END_CURRENT_BIT  7
`define CCR_UVLO_BIT         0
`define CCR_BATGD_LSB        3
`define CCR_REC_CUR_LSB      5
`define CCR_SPC_CHARGER_OFF  0
`define CCR_SPC_RECHARGE_OFF 1
`define CCR_SPC_THERM_OFF    2
`define CCR_SPC_CV_OFF       3
`define CCR_SPC_CC_OFF       4
`define CCR_SPC_PRIORITY     5
`define CCR_LIMIT_SRC_BIT    7
`define CCR_INT_ADAPTER_BIT  0
`define CCR_INT_LIMIT_BIT    1

// ==========================================================
// Termination method codes and timing
`define CCR_METH_AFTER_TERM  2'h0
`define CCR_METH_CURRENT     2'h2
`define CCR_CLK_PERIOD_NS    100
`define CCR_TICK_MIN         2
`define CCR_LONG_MULT        8'h05
`define CCR_TICK_CYCLES      ((`CCR_TICK_MIN * 64'd60_000_000_000) / \
                              `CCR_CLK_PERIOD_NS)

`endif

// File: verilog/ccr_pkg.sv
// Types shared by the charger control register block
package ccr_pkg;

    typedef enum logic [2:0] {
        CCR_HOLD     = 3'h0,
        CCR_RECOVERY = 3'h1,
        CCR_CC       = 3'h3,
        CCR_CV       = 3'h2,
        CCR_DONE     = 3'h6
    } ccr_state_t;

    typedef struct packed {
        logic adapter_present;
        logic bat_cold;
        logic bat_hot;
        logic bat_unrecoverable;
        logic below_battery_good;
        logic cv_reached;
        logic at_term_current;
        logic vsys_low;
        logic input_current_limited;
        logic recharge_needed;
        logic external_limit_pin;
    } ccr_sense_t;

    typedef struct packed {
        logic       charge_enable;
        logic       charge_reduce;
        logic       constant_voltage_loop_off;
        logic       constant_current_loop_off;
        logic       thermistor_functions_off;
        logic       termination_current_select;
        logic       undervoltage_lockout_select;
        logic [1:0] battery_good_threshold;
        logic [2:0] recovery_charge_current;
        logic       internal_limit_source;
        logic       limit_high_from_pin;
        logic [1:0] charger_mode;
    } ccr_ctrl_t;

endpackage
